// ### reset_standby_sync_control.sv
// Purpose: power-on, hard and soft reset, hard standby and frame sync trigger control
// Assumes: host drives standby, frame sync and serial writes; reset pin has an external pull model
// Notes: trigger and frame valid outputs are tri-stated by their enables while in reset
`timescale 1ns/1ps

// Summary of operation
// - internal reset generated at power up
// - low hard reset input resets device
// - all outputs high impedance during reset; only trigger and frame valid enables drop
// - serial soft reset write resets device; ignored while in standby
// - standby high enters, low leaves standby
// - broadcast sync pulse starts streaming
// - frame sync forwarded to sensor trigger
// - single-shot: one frame per trigger
// - continuous: frames from trigger onward
// - aligned cameras within five pixel clocks
// - frame sync receiver always enabled
// - reset active low, pulled up
module reset_standby_sync_control
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic standby_i,
	input wire logic frame_sync_i,
	input wire logic soft_reset_wr_i,
	input wire logic trig_mode_wr_i,
	input wire logic trig_mode_data_i,
	input wire logic sensor_fv_i,
	output logic core_reset_n_o,
	output logic serial_ready_o,
	output logic standby_o,
	output logic trigger_o,
	output logic trigger_oe_o,
	output logic host_frame_valid_o,
	output logic host_frame_valid_oe_o,
	output logic trig_mode_o
);
	logic standby_s;
	logic fsync_s;
	logic sfv_s;
	logic [4:0] por_cnt_q;
	logic [4:0] por_cnt_d;
	logic [6:0] hold_cnt_q;
	logic [6:0] hold_cnt_d;
	rst_sync_pkg::pwr_state_t pwr_q;
	rst_sync_pkg::pwr_state_t pwr_d;
	rst_sync_pkg::stream_state_t str_q;
	rst_sync_pkg::stream_state_t str_d;
	logic mode_q;
	logic mode_d;
	logic fsync_q;
	logic fsync_d;
	logic sfv_q;
	logic sfv_d;
	logic [3:0] trig_cnt_q;
	logic [3:0] trig_cnt_d;
	logic fv_q;
	logic fv_d;
	logic fs_rise;
	logic fv_rise;
	logic fv_fall;
	logic active;

	// standby, frame sync and sensor frame valid pins pass two flip-flops; frame sync receiver never gated
	sync_2ff u_sync_stby (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b0),
		.async_i(standby_i), .sync_o(standby_s));
	sync_2ff u_sync_fs (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b0),
		.async_i(frame_sync_i), .sync_o(fsync_s));
	sync_2ff u_sync_fv (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b0),
		.async_i(sensor_fv_i), .sync_o(sfv_s));

	assign fs_rise = fsync_s & ~fsync_q;
	assign fv_rise = sfv_s & ~sfv_q;
	assign fv_fall = ~sfv_s & sfv_q;
	assign active = (pwr_q != rst_sync_pkg::PWR_RESET);

	// power state: por stretch, soft reset, standby
	always_comb
	begin
		pwr_d = pwr_q;
		por_cnt_d = por_cnt_q;
		hold_cnt_d = hold_cnt_q;
		case (pwr_q)
			rst_sync_pkg::PWR_RESET:
			begin
				hold_cnt_d = 7'h00; // serial holdoff restarts after soft reset too
				if (por_cnt_q == rst_sync_pkg::POR_CYCLES_W)
					pwr_d = rst_sync_pkg::PWR_RUN;
				else
					por_cnt_d = por_cnt_q + 5'h01;
			end
			rst_sync_pkg::PWR_RUN:
			begin
				if (hold_cnt_q != rst_sync_pkg::SERIAL_HOLDOFF_W)
					hold_cnt_d = hold_cnt_q + 7'h01;
				if (soft_reset_wr_i)
				begin
					pwr_d = rst_sync_pkg::PWR_RESET;
					por_cnt_d = 5'h00;
				end
				else if (standby_s)
					pwr_d = rst_sync_pkg::PWR_STANDBY;
			end
			rst_sync_pkg::PWR_STANDBY:
			begin
				if (!standby_s)
					pwr_d = rst_sync_pkg::PWR_RUN;
			end
			default:
				pwr_d = rst_sync_pkg::PWR_RESET;
		endcase
	end

	// hard reset low forces reset, asynchronously
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pwr_q <= rst_sync_pkg::PWR_RESET;
			por_cnt_q <= 5'h00;
			hold_cnt_q <= 7'h00;
		end
		else
		begin
			pwr_q <= pwr_d;
			por_cnt_q <= por_cnt_d;
			hold_cnt_q <= hold_cnt_d;
		end
	end

	// trigger mode setting, stream state, trigger stretch and frame valid
	always_comb
	begin
		mode_d = mode_q;
		str_d = str_q;
		trig_cnt_d = trig_cnt_q;
		fsync_d = fsync_s;
		sfv_d = sfv_s;
		fv_d = fv_q;
		if (trig_mode_wr_i && active)
			mode_d = trig_mode_data_i;
		if (trig_cnt_q != 4'h0)
			trig_cnt_d = trig_cnt_q - 4'h1;
		if (fs_rise && active)
			trig_cnt_d = rst_sync_pkg::TRIG_WIDTH_W;
		case (str_q)
			rst_sync_pkg::STR_IDLE:
			begin
				if (fs_rise && pwr_q == rst_sync_pkg::PWR_RUN)
					str_d = mode_q ? rst_sync_pkg::STR_CONT : rst_sync_pkg::STR_ARMED;
			end
			rst_sync_pkg::STR_ARMED:
			begin
				if (fv_rise)
				begin
					str_d = rst_sync_pkg::STR_SINGLE;
					fv_d = 1'b1;
				end
			end
			rst_sync_pkg::STR_SINGLE:
			begin
				if (fv_fall)
				begin
					str_d = rst_sync_pkg::STR_IDLE;
					fv_d = 1'b0;
				end
			end
			rst_sync_pkg::STR_CONT:
			begin
				fv_d = sfv_s;
			end
			default:
				str_d = rst_sync_pkg::STR_IDLE;
		endcase
		if (pwr_q != rst_sync_pkg::PWR_RUN)
		begin
			str_d = rst_sync_pkg::STR_IDLE;
			fv_d = 1'b0;
		end
	end

	// stream registers
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mode_q <= rst_sync_pkg::TRIG_MODE_RESET;
			str_q <= rst_sync_pkg::STR_IDLE;
			trig_cnt_q <= 4'h0;
			fsync_q <= 1'b0;
			sfv_q <= 1'b0;
			fv_q <= 1'b0;
		end
		else
		begin
			mode_q <= mode_d;
			str_q <= str_d;
			trig_cnt_q <= trig_cnt_d;
			fsync_q <= fsync_d;
			sfv_q <= sfv_d;
			fv_q <= fv_d;
		end
	end

	// outputs; enables drop in reset so pins float
	assign core_reset_n_o = active;
	assign serial_ready_o = active && (hold_cnt_q == rst_sync_pkg::SERIAL_HOLDOFF_W);
	assign standby_o = (pwr_q == rst_sync_pkg::PWR_STANDBY);
	assign trigger_o = (trig_cnt_q != 4'h0);
	assign trigger_oe_o = active;
	assign host_frame_valid_o = fv_q;
	assign host_frame_valid_oe_o = active;
	assign trig_mode_o = mode_q;

	AST_RESET_FLOAT: assert property (@(posedge ref_clk_i) !reset_n_i |-> !trigger_oe_o && !host_frame_valid_oe_o)
		else $error("outputs enabled during reset");
	AST_POR_RELEASE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(core_reset_n_o) |-> $past(por_cnt_q) == rst_sync_pkg::POR_CYCLES_W)
		else $error("reset released early");
	AST_HARD_RESET: assert property (@(posedge ref_clk_i) $fell(reset_n_i) |=> !core_reset_n_o)
		else $error("hard reset not taken");
	AST_SOFT_RESET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		soft_reset_wr_i && pwr_q == rst_sync_pkg::PWR_RUN |=> !core_reset_n_o)
		else $error("soft reset ignored");
	AST_STBY_ENTER: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		pwr_q == rst_sync_pkg::PWR_RUN && !soft_reset_wr_i && standby_s |=> standby_o)
		else $error("standby not entered");
	AST_TRIG_FWD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		fs_rise && active |=> trigger_o [*4])
		else $error("trigger not forwarded");
	AST_SINGLE_END: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		str_q == rst_sync_pkg::STR_SINGLE && fv_fall && pwr_q == rst_sync_pkg::PWR_RUN |=> str_q == rst_sync_pkg::STR_IDLE)
		else $error("single shot did not stop");
	AST_CONT_FOLLOW: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		str_q == rst_sync_pkg::STR_CONT && pwr_q == rst_sync_pkg::PWR_RUN |=> host_frame_valid_o == $past(sfv_s))
		else $error("continuous frame valid lost");
	AST_MODE_WRITE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		trig_mode_wr_i && active |=> trig_mode_o == $past(trig_mode_data_i))
		else $error("mode write lost");
	AST_HOLDOFF: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(core_reset_n_o) |-> !serial_ready_o [*8])
		else $error("serial ready too soon");
	COV_SINGLE: cover property (@(posedge ref_clk_i) str_q == rst_sync_pkg::STR_SINGLE);
	COV_CONT: cover property (@(posedge ref_clk_i) str_q == rst_sync_pkg::STR_CONT);
	COV_STBY: cover property (@(posedge ref_clk_i) standby_o);
	COV_SOFT: cover property (@(posedge ref_clk_i) soft_reset_wr_i && active);
endmodule

// ### rst_sync_pkg.sv
// Purpose: shared constants for the reset, standby and frame sync control block
// Assumes: one clock, the master input clock at 200 MHz in simulation
// Notes: timing counts are derived from printed cycle figures
package rst_sync_pkg;
	// power-on reset stretch, in master clock cycles
	localparam int POR_CYCLES = 16;
	localparam logic [4:0] POR_CYCLES_W = 5'h10;
	// serial access holdoff after reset release, in master clock cycles
	localparam int SERIAL_HOLDOFF_CYCLES = 100;
	localparam logic [6:0] SERIAL_HOLDOFF_W = 7'h64;
	// trigger pulse width forwarded to the sensor, in cycles
	localparam logic [3:0] TRIG_WIDTH_W = 4'h4;
	// trigger mode reset value: single-shot
	localparam logic TRIG_MODE_RESET = 1'b0;
	// frame valid alignment tolerance, host pixel clock cycles
	localparam int FV_ALIGN_CYCLES = 5;
	typedef enum logic [1:0] {PWR_RESET, PWR_RUN, PWR_STANDBY} pwr_state_t;
	typedef enum logic [1:0] {STR_IDLE, STR_ARMED, STR_SINGLE, STR_CONT} stream_state_t;
endpackage

// ### sync_2ff.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: input is asynchronous to ref_clk_i
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module sync_2ff
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic rst_val_i,
	input wire logic async_i,
	output logic sync_o
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	// next values
	always_comb
	begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	// two stage register; reset value constant per instance wiring
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q ^ rst_val_i;
endmodule

// ### sensor_model.sv
// Purpose: attached sensor model, streams frames once triggered
// Assumes: frame timing is arbitrary but fixed
// Notes: keeps streaming until reset, so single-shot gating is visible
`timescale 1ns/1ps
module sensor_model
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic trigger_i,
	output logic fv_o
);
	logic run_q;
	logic [4:0] cnt_q;
	// start on trigger, frame high 12 of every 24 cycles
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			run_q <= 1'b0;
			cnt_q <= 5'h00;
		end
		else
		begin
			if (trigger_i === 1'b1)
				run_q <= 1'b1;
			if (run_q)
				cnt_q <= (cnt_q == 5'h17) ? 5'h00 : cnt_q + 5'h01;
		end
	end
	assign fv_o = run_q && (cnt_q < 5'h0C);
endmodule

// ### reset_standby_sync_control_tb.sv
// Purpose: self-checking bench for reset, standby and frame sync control
// Assumes: one clock runs throughout at a fixed 200 MHz
// Notes: random sync widths from a fixed seed
`timescale 1ns/1ps
module reset_standby_sync_control_tb;
	logic ref_clk_i = 1'b0;
	logic reset_n_i;
	logic standby_i = 1'b0;
	logic frame_sync_i = 1'b0;
	logic soft_reset_wr_i = 1'b0;
	logic trig_mode_wr_i = 1'b0;
	logic trig_mode_data_i = 1'b0;
	logic sensor_fv_i, core_reset_n_o, serial_ready_o, standby_o, trigger_o, trigger_oe_o;
	logic host_frame_valid_o, host_frame_valid_oe_o, trig_mode_o;
	logic fv_prev = 1'b0;
	int n_fail = 0;
	int total_checks = 0;
	int seed = 61;
	int frames = 0;
	int c, f0;
	always #2.5 ref_clk_i = ~ref_clk_i;
	reset_standby_sync_control i_reset_standby_sync_control (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.standby_i(standby_i), .frame_sync_i(frame_sync_i), .soft_reset_wr_i(soft_reset_wr_i),
		.trig_mode_wr_i(trig_mode_wr_i), .trig_mode_data_i(trig_mode_data_i), .sensor_fv_i(sensor_fv_i),
		.core_reset_n_o(core_reset_n_o), .serial_ready_o(serial_ready_o), .standby_o(standby_o),
		.trigger_o(trigger_o), .trigger_oe_o(trigger_oe_o), .host_frame_valid_o(host_frame_valid_o),
		.host_frame_valid_oe_o(host_frame_valid_oe_o), .trig_mode_o(trig_mode_o));
	sensor_model i_sensor_model (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .trigger_i(trigger_o),
		.fv_o(sensor_fv_i));
	// count host frame starts
	always @(posedge ref_clk_i)
	begin
		fv_prev <= host_frame_valid_o;
		if (host_frame_valid_o === 1'b1 && fv_prev !== 1'b1)
			frames <= frames + 1;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	// bounded wait for a level, returns edges taken
	task automatic wait_lvl(ref logic sig, input logic lvl, output int cyc);
		cyc = 0;
		while (sig !== lvl)
		begin
			@(posedge ref_clk_i);
			#1;
			cyc++;
			if (cyc > 2000)
			begin
				check("wait", 0, 1);
				test_done();
			end
		end
	endtask
	// sync pulse held past the trigger, trigger three cycles late and four wide
	task automatic sync_pulse(input int w);
		@(posedge ref_clk_i);
		frame_sync_i <= 1'b1;
		wait_lvl(trigger_o, 1'b1, c);
		check("trigger delay", c, 3);
		wait_lvl(trigger_o, 1'b0, c);
		check("trigger width", c, 4);
		repeat (w) @(posedge ref_clk_i);
		frame_sync_i <= 1'b0;
	endtask
	task automatic set_mode(input logic m);
		@(posedge ref_clk_i);
		trig_mode_wr_i <= 1'b1;
		trig_mode_data_i <= m;
		@(posedge ref_clk_i);
		trig_mode_wr_i <= 1'b0;
		#1;
		check("mode", trig_mode_o, m);
	endtask
	initial
	begin
		reset_n_i <= 1'b0;
		repeat (12) @(posedge ref_clk_i);
		#1;
		check("oe in reset", {trigger_oe_o, host_frame_valid_oe_o, core_reset_n_o}, 0);
		@(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		wait_lvl(core_reset_n_o, 1'b1, c);
		check("power-on stretch", c, rst_sync_pkg::POR_CYCLES + 1);
		check("oe in run", {trigger_oe_o, host_frame_valid_oe_o}, 2'h3);
		wait_lvl(serial_ready_o, 1'b1, c);
		check("serial holdoff", c >= rst_sync_pkg::SERIAL_HOLDOFF_CYCLES, 1);
		$display("reset test done");
		set_mode(1'b0);
		repeat (3)
		begin
			f0 = frames;
			sync_pulse(2 + $unsigned($random(seed)) % 8);
			repeat (150) @(posedge ref_clk_i);
			check("single frames", frames - f0, 1);
		end
		$display("single-shot test done");
		set_mode(1'b1);
		f0 = frames;
		sync_pulse(3);
		repeat (150) @(posedge ref_clk_i);
		check("continuous frames", frames - f0 >= 4, 1);
		$display("continuous test done");
		@(posedge ref_clk_i);
		standby_i <= 1'b1;
		wait_lvl(standby_o, 1'b1, c);
		sync_pulse(2);
		f0 = frames;
		repeat (10) @(posedge ref_clk_i);
		standby_i <= 1'b0;
		wait_lvl(standby_o, 1'b0, c);
		check("standby exit", c <= 3, 1);
		repeat (40) @(posedge ref_clk_i);
		check("no stream after standby", frames - f0, 0);
		$display("standby test done");
		@(posedge ref_clk_i);
		soft_reset_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		soft_reset_wr_i <= 1'b0;
		#1;
		check("soft reset", core_reset_n_o, 0);
		wait_lvl(core_reset_n_o, 1'b1, c);
		check("soft reset stretch", c, rst_sync_pkg::POR_CYCLES + 1);
		check("soft holdoff", serial_ready_o, 0);
		@(posedge ref_clk_i);
		reset_n_i <= 1'b0;
		repeat (10) @(posedge ref_clk_i);
		#1;
		check("hard reset", {trigger_oe_o, host_frame_valid_oe_o, core_reset_n_o}, 0);
		$display("reset in run test done");
		test_done();
	end
endmodule
